// >>> dcae_cfg.svh
// Constants of the chain address enumeration: codes, field layout, resets, host map, timing.
`ifndef DCAE_CFG_SVH
`define DCAE_CFG_SVH

// Packet codes and field layout.
`define DCAE_CMD_ENUM      8'h57
`define DCAE_BYTE_ZERO     8'h00
`define DCAE_CMD_REV       8'hA5
`define DCAE_ADDR_W        5
`define DCAE_ADDR_MSB      4
`define DCAE_PAD_LSB       5
`define DCAE_ADDR_MAX      5'h1F
`define DCAE_ADDR_RST      5'h00
`define DCAE_PERMIT_RST    1'b1

// Host register offsets (byte addresses) and field positions.
`define DCAE_REG_CTRL      4'h0
`define DCAE_REG_SEED      4'h4
`define DCAE_REG_STATUS    4'h8
`define DCAE_CTRL_START    0
`define DCAE_CTRL_DOWN     1
`define DCAE_ST_BUSY       0
`define DCAE_ST_DONE       1
`define DCAE_ST_TMO        2
`define DCAE_ST_ERR        3
`define DCAE_ST_RET_LSB    8
`define DCAE_ST_CNT_LSB    16
`define DCAE_ST_TOP_LSB    24
`define DCAE_SEED_RST      5'h00

// Answer timeout of the host.
`define DCAE_CLK_MHZ       25
`define DCAE_RSP_TMO_US    1000
`define DCAE_RSP_TMO_CYC   (`DCAE_RSP_TMO_US * `DCAE_CLK_MHZ)
`define DCAE_TMR_W         16

`endif

// >>> dcae_pkg.sv
// Types shared by both ends of the chain address enumeration.
`include "dcae_cfg.svh"
package dcae_pkg;

    typedef logic [`DCAE_ADDR_W-1:0] dcae_addr_t;

    // Device state; index 0 is the up path, index 1 the down path.
    typedef struct packed {
        dcae_addr_t      addr;
        logic            permit;
        logic            stored;
        logic [1:0][1:0] idx;
        logic [1:0]      hit;
        logic [1:0]      live;
        logic [1:0][7:0] tx_data;
        logic [1:0]      tx_valid;
        logic [1:0]      tx_stop;
    } dcae_dev_state_t;

    typedef enum logic [2:0] {
        DCAE_H_IDLE,
        DCAE_H_REV,
        DCAE_H_CMD,
        DCAE_H_ZERO,
        DCAE_H_SEED,
        DCAE_H_WAIT
    } dcae_host_fsm_t;

    typedef struct packed {
        dcae_host_fsm_t          fsm;
        logic                    down;
        dcae_addr_t              seed;
        logic                    busy;
        logic                    done;
        logic                    tmo;
        logic                    err;
        dcae_addr_t              ret;
        logic [5:0]              cnt;
        dcae_addr_t              top;
        logic [`DCAE_TMR_W-1:0]  tmr;
        logic [7:0]              tx_data;
        logic                    tx_valid;
        logic                    tx_stop;
        logic                    tx_dn;
        logic [1:0]              ridx;
        logic                    rhit;
        logic                    ack;
        logic [31:0]             rdata;
    } dcae_host_state_t;

endpackage : dcae_pkg

// >>> dcae_link_if.sv
// Byte-level link between the host and the chain device: two paths, two directions each.
`timescale 1ns/1ps
`include "dcae_cfg.svh"
interface dcae_link_if;
    // Up path: host to lower receive port, upper transmit port back to host.
    logic [7:0] up_in_data;
    logic       up_in_valid;
    logic       up_in_stop;
    logic [7:0] up_out_data;
    logic       up_out_valid;
    logic       up_out_stop;
    // Down path: host to upper receive port, lower transmit port back to host.
    logic [7:0] dn_in_data;
    logic       dn_in_valid;
    logic       dn_in_stop;
    logic [7:0] dn_out_data;
    logic       dn_out_valid;
    logic       dn_out_stop;

    modport dev (
        input  up_in_data, up_in_valid, up_in_stop,
        input  dn_in_data, dn_in_valid, dn_in_stop,
        output up_out_data, up_out_valid, up_out_stop,
        output dn_out_data, dn_out_valid, dn_out_stop
    );

    modport host (
        output up_in_data, up_in_valid, up_in_stop,
        output dn_in_data, dn_in_valid, dn_in_stop,
        input  up_out_data, up_out_valid, up_out_stop,
        input  dn_out_data, dn_out_valid, dn_out_stop
    );
endinterface : dcae_link_if

// >>> dcae_dev.sv
// Chain device end: stores its address from the enumeration packet and forwards it.
`timescale 1ns/1ps
`include "dcae_cfg.svh"

module dcae_dev (
    input  wire logic       clock_i,
    input  wire logic       rst_n_i,
    dcae_link_if.dev        link,
    input  wire logic       single_port_i,
    input  wire logic       host_path_sel_i,
    input  wire logic       loopback_cfg_i,
    input  wire logic       permit_set_i,
    output logic [4:0]      device_address_o,
    output logic            address_rewrite_permit_o,
    output logic            address_stored_o
);

    dcae_pkg::dcae_dev_state_t st_r;
    dcae_pkg::dcae_dev_state_t st_nxt;

    logic [1:0][7:0] in_b;
    logic [1:0]      in_v;
    logic [1:0]      in_s;
    logic [1:0][7:0] out_b;
    logic [1:0]      out_v;
    logic [1:0]      out_s;
    logic [1:0]      act;
    logic            ok;
    logic            loop;

    // Steps a received address one place along the chain of the given path.
    function automatic logic [4:0] dcae_step(input logic down,
                                             input logic [4:0] a);
        if (down) begin
            dcae_step = a - 5'h01;
        end else begin
            dcae_step = a + 5'h01;
        end
    endfunction : dcae_step

    // Path 0 receives on the lower port, path 1 on the upper port.
    assign in_b[0] = link.up_in_data;
    assign in_v[0] = link.up_in_valid;
    assign in_s[0] = link.up_in_stop;
    assign in_b[1] = link.dn_in_data;
    assign in_v[1] = link.dn_in_valid;
    assign in_s[1] = link.dn_in_stop;

    // Internal loopback only exists in single-port wiring.
    assign loop = single_port_i & loopback_cfg_i;

    // Next-state logic: parse both paths, rewrite the address byte, route the outputs.
    always_comb begin
        st_nxt       = st_r;
        out_b        = in_b;
        out_v        = in_v;
        out_s        = in_s;
        ok           = 1'b0;
        st_nxt.stored = 1'b0;
        // Only one path may take part in addressing at a time.
        act[0] = single_port_i | ~host_path_sel_i;
        act[1] = ~single_port_i & host_path_sel_i;
        for (int p = 0; p < 2; p++) begin
            if (in_v[p]) begin
                unique case (st_r.idx[p])
                    2'd0: begin
                        st_nxt.hit[p]  = (in_b[p] == `DCAE_CMD_ENUM);
                        // A locked device passes the packet through as it came.
                        st_nxt.live[p] = act[p] & st_r.permit;
                    end
                    2'd1: begin
                        st_nxt.hit[p] = st_r.hit[p] & (in_b[p] == `DCAE_BYTE_ZERO);
                    end
                    2'd2: begin
                        ok = st_r.hit[p]
                             & (in_b[p][7:`DCAE_PAD_LSB] == 3'b000);
                        st_nxt.hit[p] = ok;
                        if (ok & st_r.live[p]) begin
                            out_b[p] = {3'b000,
                                        dcae_step(p[0], in_b[p][`DCAE_ADDR_MSB:0])};
                        end
                        // Address is taken only when the stop ends a three-byte packet.
                        if (ok & st_r.live[p] & in_s[p]) begin
                            st_nxt.addr   = in_b[p][`DCAE_ADDR_MSB:0];
                            st_nxt.permit = 1'b0;
                            st_nxt.stored = 1'b1;
                        end
                    end
                    2'd3: begin
                        st_nxt.hit[p] = 1'b0;
                    end
                endcase
                // Byte counter restarts at every stop and sticks at three on long packets.
                if (in_s[p]) begin
                    st_nxt.idx[p] = 2'd0;
                end else if (st_r.idx[p] != 2'd3) begin
                    st_nxt.idx[p] = st_r.idx[p] + 2'd1;
                end
            end
        end
        // Writing the permit bit reopens addressing; it wins over a same-cycle lock.
        if (permit_set_i) begin
            st_nxt.permit = 1'b1;
        end
        // Upper transmit carries the up path unless the device turns it back.
        st_nxt.tx_data[0]  = out_b[0];
        st_nxt.tx_valid[0] = out_v[0] & ~loop;
        st_nxt.tx_stop[0]  = out_s[0] & ~loop;
        // Lower transmit carries the down path, or the up path when looped back.
        if (loop) begin
            st_nxt.tx_data[1]  = out_b[0];
            st_nxt.tx_valid[1] = out_v[0];
            st_nxt.tx_stop[1]  = out_s[0];
        end else begin
            st_nxt.tx_data[1]  = out_b[1];
            st_nxt.tx_valid[1] = out_v[1];
            st_nxt.tx_stop[1]  = out_s[1];
        end
    end

    // State register; power-on reset reopens addressing.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r          <= '0;
            st_r.addr     <= `DCAE_ADDR_RST;
            st_r.permit   <= `DCAE_PERMIT_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Link outputs come straight from the state register, one cycle behind the input.
    assign link.up_out_data  = st_r.tx_data[0];
    assign link.up_out_valid = st_r.tx_valid[0];
    assign link.up_out_stop  = st_r.tx_stop[0];
    assign link.dn_out_data  = st_r.tx_data[1];
    assign link.dn_out_valid = st_r.tx_valid[1];
    assign link.dn_out_stop  = st_r.tx_stop[1];

    // User-side status.
    assign device_address_o         = st_r.addr;
    assign address_rewrite_permit_o = st_r.permit;
    assign address_stored_o         = st_r.stored;

endmodule : dcae_dev

// >>> dcae_host.sv
// Host end: sends the enumeration packet on command from an Avalon-MM register file.
`timescale 1ns/1ps
`include "dcae_cfg.svh"
module dcae_host #(
    parameter int TMO_CYC = `DCAE_RSP_TMO_CYC
) (
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    dcae_link_if.host        link,
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic [31:0]      avs_readdata_o,
    output logic             avs_waitrequest_o
);

    localparam logic [`DCAE_TMR_W-1:0] TMO_LAST = `DCAE_TMR_W'(TMO_CYC - 1);

    // The timer must hold the whole wait.
    if (TMO_CYC < 1 || TMO_CYC >= (1 << `DCAE_TMR_W)) begin : g_chk
        $error("dcae_host: TMO_CYC out of range");
    end

    dcae_pkg::dcae_host_state_t st_r;
    dcae_pkg::dcae_host_state_t st_nxt;

    logic       acc;
    logic [7:0] rx_b;
    logic       rx_v;
    logic       rx_s;
    logic [4:0] diff;
    logic [5:0] cnt;

    // Answers may come back on either return; the down return has priority.
    assign rx_v = link.up_out_valid | link.dn_out_valid;
    assign rx_b = link.dn_out_valid ? link.dn_out_data : link.up_out_data;
    assign rx_s = link.dn_out_valid ? link.dn_out_stop : link.up_out_stop;
    assign acc  = avs_read_i | avs_write_i;

    // Count derived from the returned address; zero difference means 32 devices.
    assign diff = st_r.down ? (st_r.seed - rx_b[4:0]) : (rx_b[4:0] - st_r.seed);
    assign cnt  = (diff == 5'h00) ? 6'h20 : {1'b0, diff};

    // Next-state logic: bus slave, packet sender and answer parser.
    always_comb begin
        st_nxt          = st_r;
        st_nxt.tx_valid = 1'b0;
        st_nxt.tx_stop  = 1'b0;
        // One wait state per access; read data is caught in the first cycle.
        st_nxt.ack = acc & ~st_r.ack;
        if (acc & ~st_r.ack) begin
            unique case (avs_address_i)
                `DCAE_REG_CTRL:   st_nxt.rdata = {30'h0, st_r.down, 1'b0};
                `DCAE_REG_SEED:   st_nxt.rdata = {27'h0, st_r.seed};
                `DCAE_REG_STATUS: st_nxt.rdata = {3'h0, st_r.top, 2'h0, st_r.cnt,
                                                  3'h0, st_r.ret, 4'h0, st_r.err,
                                                  st_r.tmo, st_r.done, st_r.busy};
                default:          st_nxt.rdata = 32'h0;
            endcase
        end
        // Writes act at the edge that ends the access, one cycle after the wait state; ignored while busy.
        if (avs_write_i & st_r.ack & ~st_r.busy) begin
            if (avs_address_i == `DCAE_REG_SEED) begin
                st_nxt.seed = avs_writedata_i[4:0];
            end
            if (avs_address_i == `DCAE_REG_CTRL && avs_writedata_i[`DCAE_CTRL_START]) begin
                st_nxt.down = avs_writedata_i[`DCAE_CTRL_DOWN];
                st_nxt.busy = 1'b1;
                st_nxt.done = 1'b0;
                st_nxt.tmo  = 1'b0;
                st_nxt.err  = 1'b0;
                // Down enumeration is preceded by the reverse-path command.
                st_nxt.fsm  = avs_writedata_i[`DCAE_CTRL_DOWN] ? dcae_pkg::DCAE_H_REV
                                                               : dcae_pkg::DCAE_H_CMD;
            end
        end
        // Answer parser follows every packet and restarts on each stop.
        if (rx_v) begin
            unique case (st_r.ridx)
                2'd0:    st_nxt.rhit = (rx_b == `DCAE_CMD_ENUM);
                2'd1:    st_nxt.rhit = st_r.rhit & (rx_b == `DCAE_BYTE_ZERO);
                default: st_nxt.rhit = 1'b0;
            endcase
            st_nxt.ridx = rx_s ? 2'd0 : ((st_r.ridx == 2'd3) ? 2'd3 : st_r.ridx + 2'd1);
        end
        unique case (st_r.fsm)
            dcae_pkg::DCAE_H_IDLE: begin
            end
            dcae_pkg::DCAE_H_REV: begin
                st_nxt.tx_data  = `DCAE_CMD_REV;
                st_nxt.tx_valid = 1'b1;
                st_nxt.tx_stop  = 1'b1;
                st_nxt.tx_dn    = 1'b1;
                st_nxt.fsm      = dcae_pkg::DCAE_H_CMD;
            end
            dcae_pkg::DCAE_H_CMD: begin
                st_nxt.tx_data  = `DCAE_CMD_ENUM;
                st_nxt.tx_valid = 1'b1;
                st_nxt.tx_dn    = st_r.down;
                st_nxt.fsm      = dcae_pkg::DCAE_H_ZERO;
            end
            dcae_pkg::DCAE_H_ZERO: begin
                st_nxt.tx_data  = `DCAE_BYTE_ZERO;
                st_nxt.tx_valid = 1'b1;
                st_nxt.fsm      = dcae_pkg::DCAE_H_SEED;
            end
            dcae_pkg::DCAE_H_SEED: begin
                st_nxt.tx_data  = {3'b000, st_r.seed};
                st_nxt.tx_valid = 1'b1;
                st_nxt.tx_stop  = 1'b1;
                st_nxt.tmr      = '0;
                st_nxt.fsm      = dcae_pkg::DCAE_H_WAIT;
            end
            dcae_pkg::DCAE_H_WAIT: begin
                st_nxt.tmr = st_r.tmr + `DCAE_TMR_W'(1);
                if (rx_v & rx_s & (st_r.ridx == 2'd2) & st_r.rhit
                    & (rx_b[7:5] == 3'b000)) begin
                    st_nxt.ret  = rx_b[4:0];
                    st_nxt.cnt  = cnt;
                    // Top address for the later top-address write by software.
                    st_nxt.top  = st_r.down ? st_r.seed
                                            : (st_r.seed + cnt[4:0] - 5'h01);
                    // Flags a seed that pushed an address past either end.
                    st_nxt.err  = st_r.down ? (cnt > ({1'b0, st_r.seed} + 6'h01))
                                            : (({1'b0, st_r.seed} + cnt) > 6'h20);
                    st_nxt.done = 1'b1;
                    st_nxt.busy = 1'b0;
                    st_nxt.fsm  = dcae_pkg::DCAE_H_IDLE;
                end else if (st_r.tmr == TMO_LAST) begin
                    // No answer marks the end of the stack during loopback probing.
                    st_nxt.tmo  = 1'b1;
                    st_nxt.done = 1'b1;
                    st_nxt.busy = 1'b0;
                    st_nxt.fsm  = dcae_pkg::DCAE_H_IDLE;
                end
            end
        endcase
    end

    // State register.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r      <= '0;
            st_r.fsm  <= dcae_pkg::DCAE_H_IDLE;
            st_r.seed <= `DCAE_SEED_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Bus answer and link drive.
    assign avs_waitrequest_o = acc & ~st_r.ack;
    assign avs_readdata_o    = st_r.rdata;
    assign link.up_in_data   = st_r.tx_data;
    assign link.up_in_valid  = st_r.tx_valid & ~st_r.tx_dn;
    assign link.up_in_stop   = st_r.tx_stop & ~st_r.tx_dn;
    assign link.dn_in_data   = st_r.tx_data;
    assign link.dn_in_valid  = st_r.tx_valid & st_r.tx_dn;
    assign link.dn_in_stop   = st_r.tx_stop & st_r.tx_dn;

endmodule : dcae_host

// >>> dcae_checker.sv
// Concurrent checks on the link that joins the host end to the device end.
`timescale 1ns/1ps
module dcae_checker (
    input wire logic       clock_i,
    input wire logic       rst_n_i,
    input wire logic [7:0] up_in_data,
    input wire logic       up_in_valid,
    input wire logic       up_in_stop,
    input wire logic [7:0] up_out_data,
    input wire logic       up_out_valid,
    input wire logic       up_out_stop,
    input wire logic [7:0] dn_in_data,
    input wire logic       dn_in_valid,
    input wire logic       dn_in_stop,
    input wire logic [7:0] dn_out_data,
    input wire logic       dn_out_valid,
    input wire logic       dn_out_stop
);
    // Return stream is the upper port, or the lower port when looped back.
    logic [7:0] ret_data;
    logic       ret_valid;
    logic       ret_stop;
    logic [4:0] up_inc;
    logic [4:0] dn_dec;
    assign ret_valid = up_out_valid | dn_out_valid;
    assign ret_data  = up_out_valid ? up_out_data : dn_out_data;
    assign ret_stop  = up_out_valid ? up_out_stop : dn_out_stop;
    assign up_inc    = up_in_data[4:0] + 5'h01;
    assign dn_dec    = dn_in_data[4:0] - 5'h01;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    // An enumeration packet is the command, a zero byte, then the address byte with stop.
    sequence s_up_cmd;
        up_in_valid && up_in_data == 8'h57 && !up_in_stop;
    endsequence
    sequence s_up_tail;
        up_in_valid && up_in_data == 8'h00 ##1 up_in_valid && up_in_stop && up_in_data[7:5] == 3'h0;
    endsequence
    sequence s_dn_cmd;
        dn_in_valid && dn_in_data == 8'h57 && !dn_in_stop;
    endsequence
    sequence s_dn_tail;
        dn_in_valid && dn_in_data == 8'h00 ##1 dn_in_valid && dn_in_stop && dn_in_data[7:5] == 3'h0;
    endsequence

    a_up_pkt_form: assert property (s_up_cmd |=> s_up_tail)
        else $error("up path packet malformed");
    a_dn_pkt_form: assert property (s_dn_cmd |=> s_dn_tail)
        else $error("down path packet malformed");
    a_up_fwd_next: assert property (up_in_valid |=> ret_valid && ret_stop == $past(up_in_stop))
        else $error("up byte not forwarded next cycle");
    a_dn_fwd_next: assert property (dn_in_valid |=> dn_out_valid && dn_out_stop == $past(dn_in_stop))
        else $error("down byte not forwarded next cycle");
    a_up_out_cause: assert property (up_out_valid |-> $past(up_in_valid))
        else $error("upper transmit without received byte");
    a_hdr_kept: assert property (up_in_valid && !up_in_stop |=> ret_data == $past(up_in_data))
        else $error("header byte altered");
    a_up_addr_step: assert property (up_in_valid && up_in_stop |=>
        ret_data == $past(up_in_data) || ret_data == {3'h0, $past(up_inc)})
        else $error("up address byte not kept or incremented");
    a_dn_addr_step: assert property (dn_in_valid && dn_in_stop |=>
        dn_out_data == $past(dn_in_data) || dn_out_data == {3'h0, $past(dn_dec)})
        else $error("down address byte not kept or decremented");
endmodule : dcae_checker

// >>> test_daisy_chain_address_enumeration.sv
// Testbench: host end and device end joined, plus a second device driven directly.
`timescale 1ns/1ps
`include "dcae_cfg.svh"
module test_daisy_chain_address_enumeration;
    logic        clock_i;
    logic        rst_n_i;
    logic        single_port, path_sel, loopback, permit_set;
    logic [3:0]  avs_address;
    logic        avs_read, avs_write, avs_waitrequest;
    logic [31:0] avs_writedata, avs_readdata;
    logic [4:0]  dev_addr, dev2_addr;
    logic        dev_permit, dev_stored;
    int          err_count, checks, stored_cnt;
    dcae_link_if link1();
    dcae_link_if link2();

    dcae_host #(.TMO_CYC(50)) i_dcae_host (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .link(link1.host), .avs_address_i(avs_address), .avs_read_i(avs_read),
        .avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
        .avs_readdata_o(avs_readdata), .avs_waitrequest_o(avs_waitrequest));
    dcae_dev i_dcae_dev (.clock_i(clock_i), .rst_n_i(rst_n_i), .link(link1.dev),
        .single_port_i(single_port), .host_path_sel_i(path_sel), .loopback_cfg_i(loopback),
        .permit_set_i(permit_set), .device_address_o(dev_addr),
        .address_rewrite_permit_o(dev_permit), .address_stored_o(dev_stored));
    dcae_dev i_dcae_dev_2 (.clock_i(clock_i), .rst_n_i(rst_n_i), .link(link2.dev),
        .single_port_i(single_port), .host_path_sel_i(path_sel), .loopback_cfg_i(loopback),
        .permit_set_i(permit_set), .device_address_o(dev2_addr),
        .address_rewrite_permit_o(), .address_stored_o());
    dcae_checker i_dcae_checker (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .up_in_data(link1.up_in_data), .up_in_valid(link1.up_in_valid),
        .up_in_stop(link1.up_in_stop), .up_out_data(link1.up_out_data),
        .up_out_valid(link1.up_out_valid), .up_out_stop(link1.up_out_stop),
        .dn_in_data(link1.dn_in_data), .dn_in_valid(link1.dn_in_valid),
        .dn_in_stop(link1.dn_in_stop), .dn_out_data(link1.dn_out_data),
        .dn_out_valid(link1.dn_out_valid), .dn_out_stop(link1.dn_out_stop));

    // Compares one value and reports a mismatch.
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic end_of_test();
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_of_test

    // One Avalon-MM access; the request holds until waitrequest is seen low.
    task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clock_i);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= ~wr;
        // Waitrequest and read data are taken at the same rising edge.
        do begin
            @(posedge clock_i);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (avs_waitrequest !== 1'b0) begin
            err_count++;
            $display("[ERR] bus access expected answer seen none");
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : av

    task automatic mode(input logic s, input logic p, input logic l, input logic pulse);
        @(posedge clock_i);
        single_port <= s;
        path_sel <= p;
        loopback <= l;
        permit_set <= pulse;
        @(posedge clock_i);
        permit_set <= 1'b0;
    endtask : mode

    // Runs one enumeration from the host registers and judges the device.
    task automatic run_enum(input logic dn, input logic [4:0] seed, input logic [4:0] ea,
                            input logic [4:0] er, input logic ep, output logic [31:0] st);
        logic [31:0] rd;
        int n;
        n = 0;
        av(1'b1, `DCAE_REG_SEED, {27'h0, seed}, rd);
        av(1'b1, `DCAE_REG_CTRL, {30'h0, dn, 1'b1}, rd);
        do begin
            av(1'b0, `DCAE_REG_STATUS, 32'h0, st);
            n++;
        end while (st[`DCAE_ST_BUSY] !== 1'b0 && n < 100);
        chk("done", 32'(st[`DCAE_ST_DONE]), 32'h1);
        chk("returned address", 32'(st[12:8]), 32'(er));
        chk("device address", 32'(dev_addr), 32'(ea));
        chk("rewrite permit", 32'(dev_permit), 32'(ep));
    endtask : run_enum

    // Sends one packet straight to the second device and judges what it forwards.
    task automatic send2(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2,
                         input logic [7:0] eo, input logic [4:0] ea);
        @(posedge clock_i);
        link2.up_in_valid <= 1'b1;
        link2.up_in_data <= b0;
        @(posedge clock_i);
        link2.up_in_data <= b1;
        @(posedge clock_i);
        link2.up_in_data <= b2;
        link2.up_in_stop <= 1'b1;
        @(posedge clock_i);
        link2.up_in_valid <= 1'b0;
        link2.up_in_stop <= 1'b0;
        link2.up_in_data <= ~b2;
        @(negedge clock_i);
        chk("forwarded address byte", 32'(link2.up_out_data), 32'(eo));
        chk("forwarded stop", 32'(link2.up_out_stop), 32'h1);
        repeat (2) @(negedge clock_i);
        chk("second device address", 32'(dev2_addr), 32'(ea));
    endtask : send2

    task automatic t_regs();
        logic [31:0] rd;
        av(1'b0, `DCAE_REG_STATUS, 32'h0, rd);
        chk("status after reset", rd, 32'h0);
        av(1'b1, `DCAE_REG_SEED, 32'h0000_001F, rd);
        av(1'b0, `DCAE_REG_SEED, 32'h0, rd);
        chk("seed readback", rd, 32'h0000_001F);
        av(1'b1, 4'hC, 32'hFFFF_FFFF, rd);
        av(1'b0, 4'hC, 32'h0, rd);
        chk("unmapped read", rd, 32'h0);
        chk("address after reset", 32'(dev_addr), 32'h0);
        chk("permit after reset", 32'(dev_permit), 32'h1);
        $display("test regs done");
    endtask : t_regs

    task automatic t_enum();
        logic [31:0] st;
        send2(8'h57, 8'h01, 8'h03, 8'h03, 5'h00);
        send2(8'h57, 8'h00, 8'h23, 8'h23, 5'h00);
        send2(8'h56, 8'h00, 8'h03, 8'h03, 5'h00);
        send2(8'h57, 8'h00, 8'h1F, 8'h00, 5'h1F);
        run_enum(1'b0, 5'h03, 5'h03, 5'h04, 1'b0, st);
        chk("device count", 32'(st[21:16]), 32'h1);
        chk("top address", 32'(st[28:24]), 32'h3);
        run_enum(1'b0, 5'h07, 5'h03, 5'h07, 1'b0, st);
        chk("range error", 32'(st[`DCAE_ST_ERR]), 32'h1);
        chk("stores counted", 32'(stored_cnt), 32'h1);
        mode(1'b0, 1'b0, 1'b0, 1'b1);
        run_enum(1'b0, 5'h1F, 5'h1F, 5'h00, 1'b0, st);
        mode(1'b0, 1'b1, 1'b0, 1'b1);
        run_enum(1'b1, 5'h05, 5'h05, 5'h04, 1'b0, st);
        mode(1'b0, 1'b0, 1'b0, 1'b1);
        run_enum(1'b1, 5'h09, 5'h05, 5'h09, 1'b1, st);
        mode(1'b1, 1'b1, 1'b1, 1'b0);
        run_enum(1'b0, 5'h02, 5'h02, 5'h03, 1'b0, st);
        $display("test enumeration done");
    endtask : t_enum

    task automatic t_por();
        @(posedge clock_i);
        rst_n_i <= 1'b0;
        repeat (3) @(posedge clock_i);
        rst_n_i <= 1'b1;
        @(negedge clock_i);
        chk("address after reset", 32'(dev_addr), 32'h0);
        chk("permit after reset", 32'(dev_permit), 32'h1);
        $display("test reset done");
    endtask : t_por

    // Clock at 25 MHz.
    initial begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end

    // Counts address stores of the host-side device.
    always @(posedge clock_i) if (dev_stored === 1'b1) stored_cnt++;

    // Cuts a hung run short.
    initial begin
        repeat (20000) @(posedge clock_i);
        err_count++;
        end_of_test();
    end

    // Main sequence.
    initial begin
        rst_n_i = 1'b0;
        {single_port, path_sel, loopback, permit_set} = 4'h0;
        {avs_read, avs_write, avs_address, avs_writedata} = '0;
        {link2.up_in_valid, link2.up_in_stop, link2.up_in_data} = '0;
        {link2.dn_in_valid, link2.dn_in_stop, link2.dn_in_data} = '0;
        err_count = 0;
        checks = 0;
        stored_cnt = 0;
        repeat (12) @(posedge clock_i);
        rst_n_i <= 1'b1;
        t_regs();
        t_enum();
        t_por();
        end_of_test();
    end
endmodule : test_daisy_chain_address_enumeration
